// ===== core/srp_frame_protocol.sv
// serial frame protocol: shifting, frame check, decode, delayed response
// assumes the pins are from the master, the rest from logic on sys_clk_i
`timescale 1ns/100ps
`include "srp_regs.svh"

module srp_frame_protocol
  import srp_pkg::*;
#(
  parameter logic [15:0] ADDR_MASK = 16'h00ff
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic sclk_i,
  input wire logic select_low_line_n_i,
  input wire logic si_i,
  input wire logic soft_reset_i,
  input wire logic [`SRP_FRAME_W-1:0] diag_i,
  input wire logic [`SRP_FRAME_W-1:0] instruction_state_reg_i,
  input wire logic [`SRP_DATA_W-1:0] reg_rdata_i,
  output logic so_o,
  output logic so_oe_o,
  output logic reg_wr_o,
  output logic [`SRP_ADDR_W-1:0] reg_addr_o,
  output logic [`SRP_DATA_W-1:0] reg_wdata_o
);

  if (ADDR_MASK == 16'h0000) begin : g_chk
    $error("srp_frame_protocol: no implemented address");
  end

  // ****************************************
  // pin synchronisation
  // ****************************************
  srp_pins_s pin_raw;
  srp_pins_s pin_s;
  srp_state_s st_q;
  srp_state_s st_d;

  assign pin_raw = '{sclk: sclk_i, csn_n: select_low_line_n_i, si: si_i};

  srp_pin_sync #(
    .W(`SRP_PIN_W),
    .RST_VAL(3'h2)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .d_i(pin_raw),
    .q_o(pin_s)
  );

  // ****************************************
  // edges and frame decode
  // ****************************************
  logic sel_fall;
  logic commit;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_err;
  logic [`SRP_PFX_W-1:0] pfx;
  logic [`SRP_SFX_HI:0] sfx;
  logic [`SRP_ADDR_W-1:0] f_addr;
  logic addr_ok;
  logic [`SRP_FRAME_W-1:0] diag_word;
  logic [`SRP_FRAME_W-1:0] rsp_word;

  assign sel_fall = st_q.csn_prev & ~pin_s.csn_n;
  assign commit = ~st_q.csn_prev & pin_s.csn_n;
  assign sclk_rise = ~st_q.sclk_prev & pin_s.sclk;
  assign sclk_fall = st_q.sclk_prev & ~pin_s.sclk;
  assign frame_err = ((st_q.cnt & `SRP_BYTE_MASK) != '0) | ~st_q.ge16;
  assign pfx = st_q.sr[`SRP_FRAME_MSB -: `SRP_PFX_W];
  assign sfx = st_q.sr[`SRP_SFX_HI:0];
  assign f_addr = st_q.sr[`SRP_ADDR_HI:`SRP_ADDR_LO];
  assign addr_ok = ADDR_MASK[f_addr];

  // answer word, loaded when select falls
  assign diag_word = (diag_i & `SRP_MSB_CLR & ~`SRP_TER_MASK) | (st_q.transfer_fault_flag ? `SRP_TER_MASK : '0);
  always_comb begin
    unique case (st_q.kind)
      RSP_RESET: rsp_word = (instruction_state_reg_i & `SRP_MSB_CLR) | `SRP_TER_MASK;
      RSP_READ: rsp_word = {`SRP_PFX_RDRSP, st_q.addr, reg_rdata_i};
      RSP_SYNERR: rsp_word = diag_word | `SRP_ERR_MASK;
      RSP_DIAG: rsp_word = diag_word;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    st_d.sclk_prev = pin_s.sclk;
    st_d.csn_prev = pin_s.csn_n;
    st_d.wr = 1'b0;
    if (sel_fall) begin
      st_d.sr = rsp_word;
      st_d.so = rsp_word[`SRP_FRAME_MSB];
      st_d.so_oe = 1'b1;
      st_d.cnt = '0;
      st_d.ge16 = 1'b0;
    end else if (commit) begin
      st_d.so_oe = 1'b0;
      if (frame_err) begin
        st_d.transfer_fault_flag = 1'b1;
        st_d.kind = RSP_DIAG;
      end else begin
        st_d.transfer_fault_flag = 1'b0;
        if (pfx == `SRP_PFX_WR) begin
          if (addr_ok) begin
            st_d.wr = 1'b1;
            st_d.addr = f_addr;
            st_d.wdata = st_q.sr[`SRP_DATA_HI:0];
            st_d.kind = RSP_DIAG;
          end else begin
            st_d.kind = RSP_SYNERR;
          end
        end else if (pfx == `SRP_PFX_RD && sfx == `SRP_SFX_RD) begin
          if (addr_ok) begin
            st_d.addr = f_addr;
            st_d.kind = RSP_READ;
          end else begin
            st_d.kind = RSP_SYNERR;
          end
        end else if (!st_q.sr[`SRP_FRAME_MSB] && sfx == `SRP_SFX_DIAG) begin
          st_d.kind = RSP_DIAG;
        end else begin
          st_d.kind = RSP_SYNERR;
        end
      end
    end else if (!pin_s.csn_n) begin
      if (sclk_fall) begin
        st_d.sr = {st_q.sr[`SRP_FRAME_MSB-1:0], pin_s.si};
        st_d.cnt = st_q.cnt + `SRP_CNT_ONE;
        if (st_q.cnt == `SRP_CNT_MAX) begin
          st_d.ge16 = 1'b1;
        end
      end
      if (sclk_rise) begin
        st_d.so = st_q.sr[`SRP_FRAME_MSB];
      end
    end
    if (soft_reset_i) begin
      st_d.kind = RSP_RESET;
      st_d.transfer_fault_flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= '{sclk_prev: 1'b0, csn_prev: 1'b1, cnt: '0, ge16: 1'b0, sr: '0, transfer_fault_flag: 1'b1,
                kind: RSP_RESET, so: 1'b0, so_oe: 1'b0, wr: 1'b0, addr: '0, wdata: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign so_o = st_q.so;
  assign so_oe_o = st_q.so_oe;
  assign reg_wr_o = st_q.wr;
  assign reg_addr_o = st_q.addr;
  assign reg_wdata_o = st_q.wdata;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  logic [`SRP_PFX_W-1:0] pfx_p;
  assign pfx_p = pfx;

  sequence s_commit_ok;
    commit && !frame_err && !soft_reset_i;
  endsequence

  sequence s_load;
    sel_fall;
  endsequence

  a_oe_release: assert property (commit |=> !so_oe_o)
    else $error("output still driven after select rose");
  a_oe_drive: assert property (s_load |=> so_oe_o && so_o == $past(rsp_word[`SRP_FRAME_MSB]))
    else $error("output not driven with first answer bit");
  a_reset_answer: assert property (s_load ##0 (st_q.kind == RSP_RESET)
      |=> ((st_q.sr & `SRP_TER_MASK) != '0) && !st_q.sr[`SRP_FRAME_MSB])
    else $error("reset answer lacks fault flag");
  a_err_flag_set: assert property (commit && frame_err |=> st_q.transfer_fault_flag && !reg_wr_o)
    else $error("transfer error not flagged");
  a_fault_clear: assert property (s_commit_ok |=> !st_q.transfer_fault_flag)
    else $error("fault flag not cleared after good transfer");
  a_bad_write: assert property (s_commit_ok ##0 (pfx_p == 2'h3) |=> st_q.kind == RSP_SYNERR && !reg_wr_o)
    else $error("prefix 11 not a syntax error");
  a_bad_read: assert property (s_commit_ok ##0 (pfx_p == 2'h0) ##0 (sfx != `SRP_SFX_DIAG)
      |=> st_q.kind == RSP_SYNERR)
    else $error("prefix 00 read not a syntax error");
  a_reserved_addr: assert property (s_commit_ok ##0 !addr_ok ##0 (pfx_p == `SRP_PFX_WR)
      |=> st_q.kind == RSP_SYNERR && !reg_wr_o)
    else $error("reserved address accepted");
  a_write_once: assert property (s_commit_ok ##0 addr_ok ##0 (pfx_p == `SRP_PFX_WR)
      |=> reg_wr_o ##1 !reg_wr_o)
    else $error("write not a single pulse at select rise");
  a_read_delayed: assert property (s_commit_ok ##0 addr_ok ##0 (pfx_p == `SRP_PFX_RD) ##0 (sfx == `SRP_SFX_RD)
      |=> st_q.kind == RSP_READ && !so_oe_o)
    else $error("read answer not held for next transfer");
  a_shift_in: assert property (!pin_s.csn_n && sclk_fall && !commit |=> st_q.sr[0] == $past(pin_s.si))
    else $error("serial input bit not shifted in");

endmodule

// ===== core/srp_pin_sync.sv
// two-stage synchroniser for the serial pins
// assumes pins are asynchronous to sys_clk_i
`timescale 1ns/100ps
`include "srp_regs.svh"

module srp_pin_sync #(
  parameter int W = `SRP_PIN_W,
  parameter logic [`SRP_PIN_W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  if (W != `SRP_PIN_W) begin : g_chk
    $error("srp_pin_sync: width must match the pin struct");
  end

  // ****************************************
  // per-pin flop pair
  // ****************************************
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        meta_q <= RST_VAL[i];
        sync_q <= RST_VAL[i];
      end else begin
        meta_q <= d_i[i];
        sync_q <= meta_q;
      end
    end
    assign q_o[i] = sync_q;
  end

endmodule

// ===== include/srp_pkg.sv
// types of the serial frame protocol block
// assumes srp_regs.svh on the include path
`include "srp_regs.svh"

package srp_pkg;

  typedef enum logic [1:0] {
    RSP_RESET,
    RSP_DIAG,
    RSP_READ,
    RSP_SYNERR
  } srp_rsp_e;

  typedef struct packed {
    logic sclk;
    logic csn_n;
    logic si;
  } srp_pins_s;

  typedef struct packed {
    logic sclk_prev;
    logic csn_prev;
    logic [`SRP_CNT_W-1:0] cnt;
    logic ge16;
    logic [`SRP_FRAME_W-1:0] sr;
    logic transfer_fault_flag;
    srp_rsp_e kind;
    logic so;
    logic so_oe;
    logic wr;
    logic [`SRP_ADDR_W-1:0] addr;
    logic [`SRP_DATA_W-1:0] wdata;
  } srp_state_s;

endpackage

// ===== include/srp_regs.svh
// frame protocol constants: widths, field positions, prefixes, response masks
// assumes inclusion by bare name from the package and the protocol module
`ifndef SRP_REGS_SVH
`define SRP_REGS_SVH

`define SRP_FRAME_W 16
`define SRP_FRAME_MSB 15
`define SRP_ADDR_W 4
`define SRP_ADDR_HI 13
`define SRP_ADDR_LO 10
`define SRP_DATA_W 10
`define SRP_DATA_HI 9
`define SRP_CNT_W 4
`define SRP_CNT_ONE 4'h1
`define SRP_CNT_MAX 4'hf
`define SRP_BYTE_MASK 4'h7
`define SRP_PFX_WR 2'h2
`define SRP_PFX_RD 2'h1
`define SRP_SFX_RD 2'h2
`define SRP_SFX_DIAG 2'h1
`define SRP_PFX_RDRSP 2'h2
`define SRP_PFX_W 2
`define SRP_SFX_HI 1
`define SRP_TER_MASK 16'h0400
`define SRP_ERR_MASK 16'h0080
`define SRP_MSB_CLR 16'h7fff
`define SRP_SYNC_STAGES 2
`define SRP_PIN_W 3

`endif

// ===== testbench/srp_master_model.sv
// serial master model: select, clock and data toward the block
// assumes a link clock period of 125 ns and select held high between frames
`timescale 1ns/100ps

module srp_master_model (
  output logic sclk_o,
  output logic sel_n_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  // **********
  // idle levels
  // **********
  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    si_o = 1'b0;
  end

  // **********
  // one transfer
  // **********
  // n bits msb first; an undriven output shows up as x in rx
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    sel_n_o = 1'b0;
    #170;
    for (int i = n - 1; i >= 0; i--) begin
      si_o = tx[i];
      #31;
      sclk_o = 1'b1;
      #62.5;
      rx = {rx[30:0], so_oe_i ? so_i : 1'bx};
      sclk_o = 1'b0;
      #31.5;
    end
    #170;
    sel_n_o = 1'b1;
    si_o = 1'b0;
    #300;
  endtask
endmodule

// ===== testbench/testbench.sv
// self-checking bench of the frame protocol block
// assumes the master model drives the link, a small register array answers reads
`timescale 1ns/100ps
`include "srp_regs.svh"
`define chk(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end

module testbench import srp_pkg::*;;
  logic sys_clk_i, arst_n_i, soft_reset_i, so_o, so_oe_o, reg_wr_o;
  wire sclk, sel_n, si;
  logic [3:0] reg_addr_o;
  logic [9:0] reg_wdata_o;
  logic [9:0] mem [16] = '{default: 10'h000};
  logic [15:0] diag_i, instruction_state_reg_i;
  logic [31:0] rx;
  int num_errors, tests_run;
  localparam logic [15:0] DG = 16'h0001;

  srp_frame_protocol srp_frame_protocol_i (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .sclk_i(sclk), .select_low_line_n_i(sel_n), .si_i(si), .soft_reset_i(soft_reset_i),
    .diag_i(diag_i), .instruction_state_reg_i(instruction_state_reg_i), .reg_rdata_i(mem[reg_addr_o]), .so_o(so_o),
    .so_oe_o(so_oe_o), .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o));
  srp_master_model srp_master_model_i (.sclk_o(sclk), .sel_n_o(sel_n), .si_o(si),
    .so_i(so_o), .so_oe_i(so_oe_o));

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (reg_wr_o) mem[reg_addr_o] <= reg_wdata_o;
  end

  // **********
  // helpers
  // **********
  function automatic logic [15:0] dg(input logic f);
    return {1'b0, diag_i[14:11], f, diag_i[9:0]};
  endfunction
  task automatic xf(input logic [31:0] tx, input int n);
    srp_master_model_i.xfer(tx, n, rx);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // **********
  // scenarios
  // **********
  task automatic t_reset();
    `chk(so_oe_o, 1'b0)
    xf(DG, 16);
    `chk(rx[15:0], {1'b0, instruction_state_reg_i[14:11], 1'b1, instruction_state_reg_i[9:0]})
    xf(DG, 16);
    `chk(rx[15:0], dg(1'b0))
  endtask
  task automatic t_wr_rd();
    xf({2'b10, 4'h3, 10'h155}, 16);
    `chk(mem[3], 10'h155)
    xf({2'b01, 4'h3, 8'h00, 2'b10}, 16);
    `chk(rx[15:0], dg(1'b0))
    xf(DG, 16);
    `chk(rx[15:0], {2'b10, 4'h3, 10'h155})
    `chk(so_oe_o, 1'b0)
  endtask
  task automatic t_count();
    int n [3] = '{12, 17, 8};
    foreach (n[k]) begin
      xf(DG, n[k]);
      xf(DG, 16);
      `chk(rx[15:0], dg(1'b1))
    end
    xf({8'ha5, DG}, 24);
    `chk(rx[7:0], 8'ha5)
    xf(DG, 16);
    `chk(rx[15:0], dg(1'b0))
  endtask
  task automatic t_syntax();
    logic [15:0] f [4] = '{16'hcc2a, 16'h0c02, 16'h6402, 16'hb3ff};
    foreach (f[k]) begin
      xf(f[k], 16);
      xf(DG, 16);
      `chk(rx[15:0], dg(1'b0) | 16'h0080)
    end
    `chk(mem[3], 10'h155)
    `chk(mem[12], 10'h000)
  endtask
  task automatic t_soft();
    @(negedge sys_clk_i) soft_reset_i = 1'b1;
    @(negedge sys_clk_i) soft_reset_i = 1'b0;
    xf(DG, 16);
    `chk(rx[15:0], {1'b0, instruction_state_reg_i[14:11], 1'b1, instruction_state_reg_i[9:0]})
    xf(DG, 16);
    `chk(rx[15:0], dg(1'b0))
  endtask

  initial begin
    #300000;
    num_errors++;
    end_of_test();
  end
  initial begin
    arst_n_i = 1'b0;
    soft_reset_i = 1'b0;
    diag_i = 16'hf855;
    instruction_state_reg_i = 16'h8123;
    repeat (2) @(negedge sys_clk_i);
    arst_n_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    t_reset();
    t_wr_rd();
    t_count();
    t_syntax();
    t_soft();
    end_of_test();
  end
endmodule
